//--- pfm_pkg.sv
// Shared constants, types and register map of the fault protection manager.
// Assumes a single 25 MHz system clock and measurement words already digitised.

package pfm_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS   = 40;
   localparam int TRIP_DELAY_NS   = 6000;
   localparam int TRIP_DELAY_CYC  = TRIP_DELAY_NS / CLK_PERIOD_NS;
   localparam int RETRY_PERIOD_MS = 130;
   localparam int RETRY_CYC       = RETRY_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RETRY_CNT_W     = 22;

   // ****************************************
   // Widths and register map
   // ****************************************
   localparam int MV_W   = 13;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int PROD_W = 21;
   localparam logic [ADDR_W-1:0] REG_THR    = 8'h00;
   localparam logic [ADDR_W-1:0] REG_MODE   = 8'h04;
   localparam logic [ADDR_W-1:0] REG_VSET   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] REG_FAULT  = 8'h14;

   // Field positions
   localparam int THR_OC_LSB = 0;
   localparam int THR_OV_LSB = 4;
   localparam int THR_UV_LSB = 6;
   localparam int THR_PG_BIT = 8;
   localparam int MODE_TRK_EN_BIT = 5;
   localparam int CTRL_REARM_BIT  = 0;
   localparam int STAT_WARN_BIT   = 5;
   localparam int STAT_PG_BIT     = 6;
   localparam int STAT_OFF_BIT    = 7;

   // Reset values
   localparam logic [DATA_W-1:0] THR_RST  = 16'h002a;
   localparam logic [DATA_W-1:0] MODE_RST = 16'h0000;
   localparam logic [MV_W-1:0]   VSET_RST = 13'h01f4;

   // Guard and filtered-condition indices
   localparam int G_OC     = 0;
   localparam int G_OV     = 1;
   localparam int G_UV     = 2;
   localparam int G_OT     = 3;
   localparam int G_TRK    = 4;
   localparam int N_GUARD  = 5;
   localparam int N_FILT   = 7;
   localparam int F_WARN   = 5;
   localparam int F_PG     = 6;

   // Threshold arithmetic
   localparam int PCT_SCALE    = 100;
   localparam int OC_BASE_PCT  = 60;
   localparam int OC_STEP_PCT  = 11;
   localparam int OC_MAX_CODE  = 10;
   localparam int OV_BASE_PCT  = 110;
   localparam int OV_STEP_PCT  = 10;
   localparam int OV_MAX_CODE  = 2;
   localparam int UV_BASE_PCT  = 75;
   localparam int UV_STEP_PCT  = 5;
   localparam int UV_MAX_CODE  = 2;
   localparam int PG_LO_BASE   = 90;
   localparam int PG_LO_STEP   = 5;
   localparam int PG_HI_PCT    = 110;
   localparam int OV_FLOOR_MV  = 1000;
   localparam int OT_OFF_C     = 130;
   localparam int OT_ON_C      = 120;
   localparam int WARN_SET_C   = 120;
   localparam int WARN_HYST_C  = 3;
   localparam int TRK_LIMIT_MV = 250;

   // Guard sequencing states
   typedef enum logic [1:0] {
      GS_RUN  = 2'b00,
      GS_WAIT = 2'b01,
      GS_HOLD = 2'b10
   } pfm_guard_state_t;

   // Measurement bundle from the converter front end
   typedef struct packed {
      logic [MV_W-1:0] vout_mv;
      logic [MV_W-1:0] track_ref_mv;
      logic [8:0]      iout_pct;
      logic [7:0]      temp_c;
      logic            ramp_up;
      logic            settled;
   } pfm_meas_t;

endpackage

//--- pfm_delay_filter.sv
// Qualification filter: output follows input once input has held a new level.
// Assumes a synchronous active-high reset and one clock.
`timescale 1ns/1ps

module pfm_delay_filter #(
   parameter int HOLD_CYC = pfm_pkg::TRIP_DELAY_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Raw and qualified level
   input  wire logic raw,
   output logic      qual_ff
);

   logic [15:0] cnt_ff;

   // ****************************************
   // Hold counter
   // ****************************************
   // Counts cycles of disagreement and flips the output at the hold time
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff  <= 16'h0000;
         qual_ff <= 1'b0;
      end else if (raw == qual_ff) begin
         cnt_ff <= 16'h0000;
      end else if (cnt_ff == 16'(HOLD_CYC - 1)) begin
         cnt_ff  <= 16'h0000;
         qual_ff <= raw;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

endmodule

//--- pfm_guard_seq.sv
// One protection channel: turns the output off on a trip, then waits.
// Assumes a qualified trip level and a one-cycle rearm pulse from software.
`timescale 1ns/1ps

module pfm_guard_seq #(
   parameter int RETRY_CYCLES = pfm_pkg::RETRY_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Control
   input  wire logic trip,
   input  wire logic latching,
   input  wire logic rearm,
   // Result
   output logic      off_ff,
   output logic      trip_pulse
);

   pfm_pkg::pfm_guard_state_t state_ff;
   logic [pfm_pkg::RETRY_CNT_W-1:0] cnt_ff;

   assign trip_pulse = (state_ff == pfm_pkg::GS_RUN) && trip;

   // ****************************************
   // Trip, retry and hold sequencing
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= pfm_pkg::GS_RUN;
         cnt_ff   <= '0;
         off_ff   <= 1'b0;
      end else begin
         case (state_ff)
            pfm_pkg::GS_RUN: begin
               cnt_ff <= '0;
               if (trip) begin
                  off_ff   <= 1'b1;
                  state_ff <= latching ? pfm_pkg::GS_HOLD : pfm_pkg::GS_WAIT;
               end
            end
            pfm_pkg::GS_WAIT: begin
               // Retry period; restart it while the condition persists
               if (cnt_ff == pfm_pkg::RETRY_CNT_W'(RETRY_CYCLES - 1)) begin
                  cnt_ff <= '0;
                  if (!trip) begin
                     off_ff   <= 1'b0;
                     state_ff <= pfm_pkg::GS_RUN;
                  end
               end else begin
                  cnt_ff <= cnt_ff + 1'b1;
               end
            end
            pfm_pkg::GS_HOLD: begin
               if (rearm && !trip) begin
                  off_ff   <= 1'b0;
                  state_ff <= pfm_pkg::GS_RUN;
               end
            end
            default: begin
               state_ff <= pfm_pkg::GS_RUN;
               off_ff   <= 1'b0;
            end
         endcase
      end
   end

endmodule

//--- pfm_fault_manager.sv
// Fault protection and power-good supervisor of a point-of-load converter.
// Assumes digitised measurements on CLK_SYS and a plain register port from the host.
`timescale 1ns/1ps

module pfm_fault_manager #(
   parameter int RETRY_CYCLES = pfm_pkg::RETRY_CYC,
   parameter int DELAY_CYCLES = pfm_pkg::TRIP_DELAY_CYC
) (
   // Clock and reset
   input  wire logic                          CLK_SYS,
   input  wire logic                          RST,
   // Measurements
   input  wire pfm_pkg::pfm_meas_t            MEAS,
   // Register port
   input  wire logic [pfm_pkg::ADDR_W-1:0]    REG_ADDR,
   input  wire logic [pfm_pkg::DATA_W-1:0]    REG_WDATA,
   input  wire logic                          REG_WR,
   input  wire logic                          REG_RD,
   output logic      [pfm_pkg::DATA_W-1:0]    REG_RDATA,
   // Converter control and indications
   output logic                               CONV_OFF,
   output logic                               OUTPUT_IN_WINDOW_FLAG,
   output logic                               TEMP_WARN,
   output logic      [pfm_pkg::N_GUARD-1:0]   GUARD_OFF
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [pfm_pkg::DATA_W-1:0]  thr_ff;
   logic [pfm_pkg::DATA_W-1:0]  mode_ff;
   logic [pfm_pkg::MV_W-1:0]    vset_ff;
   logic [pfm_pkg::N_GUARD-1:0] fault_ff;
   logic [pfm_pkg::N_GUARD-1:0] nxt_fault;
   logic [pfm_pkg::DATA_W-1:0]  rdata_ff;
   logic                        rearm_ff;
   logic                        ot_cond_ff;
   logic                        warn_cond_ff;

   // Decoded codes and percent limits
   logic [3:0]                  oc_code;
   logic [1:0]                  ov_code;
   logic [1:0]                  uv_code;
   logic [8:0]                  oc_pct;
   logic [7:0]                  ov_pct;
   logic [7:0]                  uv_pct;
   logic [7:0]                  pg_lo_pct;

   // Voltage terms scaled by 100
   logic [pfm_pkg::PROD_W-1:0]  vout_x100;
   logic [pfm_pkg::PROD_W-1:0]  ov_lvl;
   logic [pfm_pkg::PROD_W-1:0]  ov_lim;
   logic [pfm_pkg::PROD_W-1:0]  uv_lim;
   logic [pfm_pkg::PROD_W-1:0]  pg_lo_lim;
   logic [pfm_pkg::PROD_W-1:0]  pg_hi_lim;

   // Tracking error
   logic signed [pfm_pkg::MV_W:0] trk_err;
   logic [pfm_pkg::MV_W:0]      trk_mag;

   // Per-condition and per-guard vectors
   logic [pfm_pkg::N_FILT-1:0]  raw_vec;
   logic [pfm_pkg::N_FILT-1:0]  qual_vec;
   logic [pfm_pkg::N_GUARD-1:0] off_vec;
   logic [pfm_pkg::N_GUARD-1:0] pulse_vec;
   logic [pfm_pkg::N_GUARD-1:0] latch_vec;
   logic                        trk_en;

   // Write decode
   logic                        wr_hit_thr;
   logic                        wr_hit_mode;
   logic                        wr_hit_vset;
   logic                        wr_hit_ctrl;
   logic                        wr_hit_fault;

   // ****************************************
   // Threshold code decode
   // ****************************************
   // Out-of-range codes clamp to the highest legal setting
   always_comb begin
      oc_code = thr_ff[pfm_pkg::THR_OC_LSB +: 4];
      if (oc_code > 4'(pfm_pkg::OC_MAX_CODE)) begin
         oc_code = 4'(pfm_pkg::OC_MAX_CODE);
      end
      ov_code = thr_ff[pfm_pkg::THR_OV_LSB +: 2];
      if (ov_code > 2'(pfm_pkg::OV_MAX_CODE)) begin
         ov_code = 2'(pfm_pkg::OV_MAX_CODE);
      end
      uv_code = thr_ff[pfm_pkg::THR_UV_LSB +: 2];
      if (uv_code > 2'(pfm_pkg::UV_MAX_CODE)) begin
         uv_code = 2'(pfm_pkg::UV_MAX_CODE);
      end
   end

   // Percent limits from the codes
   assign oc_pct = 9'(pfm_pkg::OC_BASE_PCT) + 9'(pfm_pkg::OC_STEP_PCT) * 9'(oc_code);
   assign ov_pct = 8'(pfm_pkg::OV_BASE_PCT) + 8'(pfm_pkg::OV_STEP_PCT) * 8'(ov_code);
   assign uv_pct = 8'(pfm_pkg::UV_BASE_PCT) + 8'(pfm_pkg::UV_STEP_PCT) * 8'(uv_code);
   assign pg_lo_pct = thr_ff[pfm_pkg::THR_PG_BIT] ?
                      8'(pfm_pkg::PG_LO_BASE + pfm_pkg::PG_LO_STEP) :
                      8'(pfm_pkg::PG_LO_BASE);

   // ****************************************
   // Voltage comparisons in percent-scaled millivolts
   // ****************************************
   // Scaling both sides by 100 avoids a divider
   assign vout_x100 = pfm_pkg::PROD_W'(MEAS.vout_mv) * pfm_pkg::PROD_W'(pfm_pkg::PCT_SCALE);
   assign ov_lvl    = pfm_pkg::PROD_W'(vset_ff) * pfm_pkg::PROD_W'(ov_pct);
   assign uv_lim    = pfm_pkg::PROD_W'(vset_ff) * pfm_pkg::PROD_W'(uv_pct);
   assign pg_lo_lim = pfm_pkg::PROD_W'(vset_ff) * pfm_pkg::PROD_W'(pg_lo_pct);
   assign pg_hi_lim = pfm_pkg::PROD_W'(vset_ff) * pfm_pkg::PROD_W'(pfm_pkg::PG_HI_PCT);

   // Overvoltage level is floored at one volt
   assign ov_lim = (ov_lvl < pfm_pkg::PROD_W'(pfm_pkg::OV_FLOOR_MV * pfm_pkg::PCT_SCALE)) ?
                   pfm_pkg::PROD_W'(pfm_pkg::OV_FLOOR_MV * pfm_pkg::PCT_SCALE) :
                   ov_lvl;

   // Tracking error magnitude
   assign trk_err = $signed({1'b0, MEAS.vout_mv}) - $signed({1'b0, MEAS.track_ref_mv});
   assign trk_mag = trk_err[pfm_pkg::MV_W] ? (pfm_pkg::MV_W + 1)'(-trk_err) :
                    (pfm_pkg::MV_W + 1)'(trk_err);
   assign trk_en  = mode_ff[pfm_pkg::MODE_TRK_EN_BIT];

   // ****************************************
   // Temperature hysteresis comparators
   // ****************************************
   // Shutdown condition holds from 130 C down to 120 C
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ot_cond_ff <= 1'b0;
      end else if (MEAS.temp_c >= 8'(pfm_pkg::OT_OFF_C)) begin
         ot_cond_ff <= 1'b1;
      end else if (MEAS.temp_c <= 8'(pfm_pkg::OT_ON_C)) begin
         ot_cond_ff <= 1'b0;
      end
   end

   // Warning condition, independent of any mode bit
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         warn_cond_ff <= 1'b0;
      end else if (MEAS.temp_c >= 8'(pfm_pkg::WARN_SET_C)) begin
         warn_cond_ff <= 1'b1;
      end else if (MEAS.temp_c <= 8'(pfm_pkg::WARN_SET_C - pfm_pkg::WARN_HYST_C)) begin
         warn_cond_ff <= 1'b0;
      end
   end

   // ****************************************
   // Raw conditions
   // ****************************************
   // Undervoltage only counts once the output has settled
   always_comb begin
      raw_vec = '0;
      raw_vec[pfm_pkg::G_OC]  = MEAS.iout_pct >= oc_pct;
      raw_vec[pfm_pkg::G_OV]  = vout_x100 > ov_lim;
      raw_vec[pfm_pkg::G_UV]  = MEAS.settled && (vout_x100 < uv_lim);
      raw_vec[pfm_pkg::G_OT]  = ot_cond_ff;
      raw_vec[pfm_pkg::G_TRK] = trk_en && MEAS.ramp_up &&
                                (trk_mag > (pfm_pkg::MV_W + 1)'(pfm_pkg::TRK_LIMIT_MV));
      raw_vec[pfm_pkg::F_WARN] = warn_cond_ff;
      raw_vec[pfm_pkg::F_PG]   = (vout_x100 >= pg_lo_lim) && (vout_x100 <= pg_hi_lim);
   end

   // ****************************************
   // Qualification delay and guard channels
   // ****************************************
   // Every condition must persist for the delay before it acts
   genvar gi;
   generate
      for (gi = 0; gi < pfm_pkg::N_FILT; gi++) begin : g_filt
         pfm_delay_filter #(
            .HOLD_CYC (DELAY_CYCLES)
         ) u_filt (
            .clk     (CLK_SYS),
            .rst     (RST),
            .raw     (raw_vec[gi]),
            .qual_ff (qual_vec[gi])
         );
      end
      // Only the first N_GUARD conditions drive a sequencer
      for (gi = 0; gi < pfm_pkg::N_GUARD; gi++) begin : g_guard
         assign latch_vec[gi] = mode_ff[gi];
         pfm_guard_seq #(
            .RETRY_CYCLES (RETRY_CYCLES)
         ) u_guard (
            .clk        (CLK_SYS),
            .rst        (RST),
            .trip       (qual_vec[gi]),
            .latching   (latch_vec[gi]),
            .rearm      (rearm_ff),
            .off_ff     (off_vec[gi]),
            .trip_pulse (pulse_vec[gi])
         );
      end
   endgenerate

   // ****************************************
   // Outputs
   // ****************************************
   // Any guard holding its output off commands the converter off
   assign CONV_OFF              = |off_vec;
   assign GUARD_OFF             = off_vec;
   assign OUTPUT_IN_WINDOW_FLAG = qual_vec[pfm_pkg::F_PG];
   assign TEMP_WARN             = qual_vec[pfm_pkg::F_WARN];
   assign REG_RDATA             = rdata_ff;

   // ****************************************
   // Register writes
   // ****************************************
   // One hit per writable register on a write strobe; REG_STATUS has none
   assign wr_hit_thr   = REG_WR && (REG_ADDR == pfm_pkg::REG_THR);
   assign wr_hit_mode  = REG_WR && (REG_ADDR == pfm_pkg::REG_MODE);
   assign wr_hit_vset  = REG_WR && (REG_ADDR == pfm_pkg::REG_VSET);
   assign wr_hit_ctrl  = REG_WR && (REG_ADDR == pfm_pkg::REG_CTRL);
   assign wr_hit_fault = REG_WR && (REG_ADDR == pfm_pkg::REG_FAULT);

   // Threshold codes, reset to the unprogrammed defaults
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         thr_ff <= pfm_pkg::THR_RST;
      end else if (wr_hit_thr) begin
         thr_ff <= REG_WDATA;
      end
   end

   // Latching mode per guard and tracking enable, all clear at reset
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         mode_ff <= pfm_pkg::MODE_RST;
      end else if (wr_hit_mode) begin
         mode_ff <= REG_WDATA;
      end
   end

   // Voltage setpoint in millivolts
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         vset_ff <= pfm_pkg::VSET_RST;
      end else if (wr_hit_vset) begin
         vset_ff <= REG_WDATA[pfm_pkg::MV_W-1:0];
      end
   end

   // Rearm pulse for latched guards
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rearm_ff <= 1'b0;
      end else begin
         rearm_ff <= wr_hit_ctrl && REG_WDATA[pfm_pkg::CTRL_REARM_BIT];
      end
   end

   // ****************************************
   // Sticky fault record
   // ****************************************
   // Write one to clear; a trip in the same cycle wins over the clear
   always_comb begin
      nxt_fault = fault_ff;
      if (wr_hit_fault) begin
         nxt_fault = fault_ff & ~REG_WDATA[pfm_pkg::N_GUARD-1:0];
      end
      nxt_fault = nxt_fault | pulse_vec;
   end

   // Fault record register
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         fault_ff <= '0;
      end else begin
         fault_ff <= nxt_fault;
      end
   end

   // ****************************************
   // Register reads
   // ****************************************
   // Data stands only in the cycle after the read strobe
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rdata_ff <= '0;
      end else if (REG_RD) begin
         case (REG_ADDR)
            pfm_pkg::REG_THR:    rdata_ff <= thr_ff;
            pfm_pkg::REG_MODE:   rdata_ff <= mode_ff;
            pfm_pkg::REG_VSET:   rdata_ff <= pfm_pkg::DATA_W'(vset_ff);
            pfm_pkg::REG_STATUS: begin
               rdata_ff <= pfm_pkg::DATA_W'({CONV_OFF, OUTPUT_IN_WINDOW_FLAG,
                                             TEMP_WARN, off_vec});
            end
            pfm_pkg::REG_FAULT:  rdata_ff <= pfm_pkg::DATA_W'(fault_ff);
            default:             rdata_ff <= '0;
         endcase
      end else begin
         rdata_ff <= '0;
      end
   end

endmodule

//--- pfm_fault_manager_properties.sv
// Port checker for the fault manager, bound to its top module.
// Assumes DELAY_CYCLES of at most 4, so eight samples cover one qualification.
`timescale 1ns/1ps

module pfm_fault_manager_properties #(
   parameter int RETRY_CYCLES = 20,
   parameter int DELAY_CYCLES = 4
) (
   // Clock and reset
   input wire logic                        CLK_SYS,
   input wire logic                        RST,
   // Measurements and register port
   input wire pfm_pkg::pfm_meas_t          MEAS,
   input wire logic [pfm_pkg::ADDR_W-1:0]  REG_ADDR,
   input wire logic [pfm_pkg::DATA_W-1:0]  REG_WDATA,
   input wire logic                        REG_WR,
   input wire logic                        REG_RD,
   input wire logic [pfm_pkg::DATA_W-1:0]  REG_RDATA,
   // Indications
   input wire logic                        CONV_OFF,
   input wire logic                        OUTPUT_IN_WINDOW_FLAG,
   input wire logic                        TEMP_WARN,
   input wire logic [pfm_pkg::N_GUARD-1:0] GUARD_OFF
);
   // ****
   // Temperature bands held long enough to qualify
   // ****
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   sequence s_hot;  (MEAS.temp_c >= 8'h82)[*8]; endsequence
   sequence s_warm; (MEAS.temp_c >= 8'h78)[*8]; endsequence
   sequence s_cool; (MEAS.temp_c <= 8'h75)[*8]; endsequence

   // Turn-off command and read port
   a_off_is_or:   assert property (CONV_OFF == (|GUARD_OFF))
      else $error("turn-off differs from guard states");
   a_rdata_idle:  assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
      else $error("read data outside its cycle");
   a_status_read: assert property (REG_RD && REG_ADDR == 8'h10 |=> REG_RDATA[7:0] ==
      {$past(CONV_OFF), $past(OUTPUT_IN_WINDOW_FLAG), $past(TEMP_WARN), $past(GUARD_OFF)})
      else $error("status word differs from outputs");
   // Temperature guard and warning
   a_ot_trip:     assert property (s_hot |-> ##[0:3] GUARD_OFF[3])
      else $error("no shutdown when hot");
   a_ot_release:  assert property ($fell(GUARD_OFF[3]) |-> $past(MEAS.temp_c, 2) < 8'h82)
      else $error("release while still hot");
   a_warn_set:    assert property (s_warm |-> ##[0:3] TEMP_WARN)
      else $error("warning late");
   a_warn_clear:  assert property (s_cool |-> ##[0:3] !TEMP_WARN)
      else $error("warning stuck");
   a_warn_rise:   assert property ($rose(TEMP_WARN) |-> $past(MEAS.temp_c, 2) > 8'h75)
      else $error("warning raised while cool");
   a_warn_fall:   assert property ($fell(TEMP_WARN) |-> $past(MEAS.temp_c, 2) < 8'h78)
      else $error("warning dropped while warm");
   // Tracking only while ramping up
   a_trk_ramp:    assert property ($rose(GUARD_OFF[4]) |-> $past(MEAS.ramp_up, 2))
      else $error("tracking trip outside ramp");
   // Current trip only at or above the lowest selectable limit
   a_oc_floor:    assert property ($rose(GUARD_OFF[0]) |->
      $past(MEAS.iout_pct, 2) >= 9'h03c) else $error("current trip below lowest limit");
endmodule

bind pfm_fault_manager pfm_fault_manager_properties #(
   .RETRY_CYCLES(RETRY_CYCLES), .DELAY_CYCLES(DELAY_CYCLES)
) u_props (
   .CLK_SYS(CLK_SYS), .RST(RST), .MEAS(MEAS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CONV_OFF(CONV_OFF),
   .OUTPUT_IN_WINDOW_FLAG(OUTPUT_IN_WINDOW_FLAG), .TEMP_WARN(TEMP_WARN), .GUARD_OFF(GUARD_OFF)
);

//--- pfm_host_model.sv
// Host power manager model driving the register port.
// Assumes read data stand in the cycle after the read strobe only.
`timescale 1ns/1ps

module pfm_host_model (
   // Clock
   input  wire logic        clk,
   // Register port
   output logic      [7:0]  addr,
   output logic      [15:0] wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [15:0] rdata
);
   // Idle bus from time zero
   initial begin
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   // One-cycle write strobe
   task automatic write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // One-cycle read strobe, word taken in the following cycle
   task automatic read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
endmodule

//--- pfm_fault_manager_tb.sv
// Self-checking bench: host model, integer reference model, bound checker.
// Assumes short retry and qualification counts handed to the design.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end

module pfm_fault_manager_tb;
   // ****
   // Signals
   // ****
   localparam int RC = 20;
   localparam int DC = 4;
   localparam int SETTLE = RC + DC + 12;
   logic               clk_sys = 1'b0;
   logic               rst = 1'b1;
   pfm_pkg::pfm_meas_t meas;
   logic [7:0]         reg_addr;
   logic [15:0]        reg_wdata;
   logic [15:0]        reg_rdata;
   logic [15:0]        rd;
   logic               reg_wr;
   logic               reg_rd;
   logic               conv_off;
   logic               win_flag;
   logic               temp_warn;
   logic [4:0]         guard_off;
   int                 n_checks = 0;
   int                 n_mismatch = 0;
   int                 seed = 42;
   int                 vset = 500;
   int                 oc, ovc, uvc, pgb, v, i, cnt, w, o;
   bit                 e_oc, e_ov, e_uv, e_pg;
   bit                 stl = 1'b1;
   int                 temps [9] = '{119, 120, 118, 117, 130, 125, 121, 120, 116};
   int                 trk [5][4] = '{'{0, 1, 300, 0}, '{1, 1, 300, 1}, '{1, 1, -300, 1},
                                      '{1, 1, 200, 0}, '{1, 0, 300, 0}};

   // Clock
   always #20 clk_sys = ~clk_sys;

   pfm_fault_manager #(.RETRY_CYCLES(RC), .DELAY_CYCLES(DC)) dut (
      .CLK_SYS(clk_sys), .RST(rst), .MEAS(meas), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .CONV_OFF(conv_off), .OUTPUT_IN_WINDOW_FLAG(win_flag), .TEMP_WARN(temp_warn),
      .GUARD_OFF(guard_off));
   pfm_host_model host (.clk(clk_sys), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr),
      .rd(reg_rd), .rdata(reg_rdata));

   // ****
   // Tasks
   // ****
   // Reference trip and window decisions in integers
   task automatic model;
      e_oc = i >= 60 + 11 * oc;
      e_ov = v * 100 > ((vset * (110 + 10 * ovc) > 100000) ? vset * (110 + 10 * ovc) : 100000);
      e_uv = stl && v * 100 < vset * (75 + 5 * uvc);
      e_pg = v * 100 >= vset * (90 + 5 * pgb) && v * 100 <= vset * 110;
   endtask
   // Measurement word from current v and i
   task automatic drive(input int t, input int rp, input int rf);
      @(posedge clk_sys);
      meas <= '{vout_mv: 13'(v), track_ref_mv: 13'(rf), iout_pct: 9'(i),
                temp_c: 8'(t), ramp_up: 1'(rp), settled: stl};
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ****
   // Main sequence
   // ****
   initial begin
      v = 500;
      i = 50;
      meas = '{vout_mv: 13'h01f4, track_ref_mv: 13'h01f4, iout_pct: 9'h032, temp_c: 8'h19,
               ramp_up: 1'b0, settled: 1'b1};
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      host.read(8'h00, rd);
      `CHK(rd, 16'h002a)
      host.read(8'h04, rd);
      `CHK(rd, 16'h0000)
      host.read(8'h14, rd);
      `CHK(rd, 16'h0000)
      $display("test reset done");
      // Random limits, setpoints and measurements
      for (int k = 0; k < 30; k++) begin
         oc = {$random(seed)} % 11;
         ovc = {$random(seed)} % 3;
         uvc = {$random(seed)} % 3;
         pgb = {$random(seed)} % 2;
         vset = (k % 4 == 0) ? 700 : 500 + {$random(seed)} % 4000;
         host.write(8'h00, 16'(oc + (ovc << 4) + (uvc << 6) + (pgb << 8)));
         host.write(8'h08, 16'(vset));
         v = vset;
         i = 50;
         drive(25, 0, v);
         settle(SETTLE);
         host.write(8'h14, 16'h001f);
         stl = (k % 5 != 3);
         v = vset * (60 + {$random(seed)} % 100) / 100;
         i = {$random(seed)} % 200;
         model();
         drive(25, 0, v);
         settle(DC + 6);
         `CHK(guard_off[2:0], {e_uv, e_ov, e_oc})
         `CHK(win_flag, e_pg)
         host.read(8'h14, rd);
         `CHK(rd[2:0], {e_uv, e_ov, e_oc})
      end
      $display("test limits done");
      // Delay, latching hold and rearm, then timed retry
      v = vset;
      i = 50;
      drive(25, 0, v);
      settle(SETTLE);
      host.write(8'h04, 16'h0001);
      i = 300;
      drive(25, 0, v);
      cnt = 0;
      while (conv_off !== 1'b1 && cnt < 50) begin
         settle(1);
         cnt++;
      end
      `CHK(cnt >= DC && cnt <= DC + 3, 1'b1)
      i = 50;
      drive(25, 0, v);
      settle(SETTLE);
      `CHK(guard_off[0], 1'b1)
      host.write(8'h0c, 16'h0001);
      settle(4);
      `CHK(guard_off[0], 1'b0)
      host.write(8'h04, 16'h0000);
      i = 300;
      drive(25, 0, v);
      settle(DC + 4);
      i = 50;
      drive(25, 0, v);
      settle(4);
      `CHK(conv_off, 1'b1)
      settle(SETTLE);
      `CHK(conv_off, 1'b0)
      $display("test modes done");
      // Temperature sweep through warning and shutdown bands
      w = 0;
      o = 0;
      foreach (temps[k]) begin
         drive(temps[k], 0, v);
         settle(SETTLE);
         w = temps[k] >= 120 ? 1 : temps[k] <= 117 ? 0 : w;
         o = temps[k] >= 130 ? 1 : temps[k] <= 120 ? 0 : o;
         `CHK(temp_warn, w[0])
         `CHK(guard_off[3], o[0])
         host.read(8'h10, rd);
         `CHK(rd[6:5], {1'b1, w[0]})
      end
      $display("test temperature done");
      // Tracking enable, ramp gating and both error directions
      foreach (trk[k]) begin
         host.write(8'h04, 16'(trk[k][0] << 5));
         drive(25, trk[k][1], vset - trk[k][2]);
         settle(SETTLE);
         `CHK(guard_off[4], 1'(trk[k][3]))
      end
      $display("test tracking done");
      print_verdict();
   end

   // Watchdog cuts a hang short
   initial begin
      #800000;
      n_mismatch++;
      print_verdict();
   end
endmodule
